/* File: core/sld_pkg.sv */
package sld_pkg;

  localparam int SLD_STAGES    = 16;
  localparam int SLD_SYNC_DEPTH = 2;

  // Positions of the pins inside the synchroniser vector.
  localparam int SLD_PIN_OE_N = 0;
  localparam int SLD_PIN_LE   = 1;
  localparam int SLD_PIN_SCLK = 2;
  localparam int SLD_PIN_SDI  = 3;
  localparam int SLD_PIN_NUM  = 4;

  // Levels an undriven enable pin settles to through its internal pull.
  localparam logic SLD_OE_N_PULL = 1'b1;
  localparam logic SLD_LE_PULL   = 1'b0;

  // Reset values.
  localparam logic SLD_SDI_RST   = 1'b0;
  localparam logic SLD_SCLK_RST  = 1'b1;
  localparam logic SLD_DATA_RST  = 1'b0;
  localparam logic SLD_SINK_RST  = 1'b0;

  typedef enum logic [2:0] {
    SLD_ST_UNKNOWN = 3'b001,
    SLD_ST_FILLED  = 3'b010,
    SLD_ST_VALID   = 3'b100
  } sld_load_t;

endpackage

/* File: core/sld_shift_if.sv */
interface sld_shift_if
  import sld_pkg::*;
#(
  parameter int STAGES = SLD_STAGES
) ();
  logic              shift_en;
  logic              din;
  logic              latch_en;
  logic [STAGES-1:0] stages;
  logic [STAGES-1:0] latched;

  modport ctrl (output shift_en, output din, output latch_en, input stages, input latched);
  modport bank (input shift_en, input din, input latch_en, output stages, output latched);
endinterface

/* File: core/sld_sync.sv */
module sld_sync
  import sld_pkg::*;
#(
  parameter int               WIDTH   = SLD_PIN_NUM,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("sld_sync needs at least one bit");
  end

  if (SLD_SYNC_DEPTH != 2) begin : g_bad_depth
    $error("sld_sync is built with exactly two stages");
  end

  // The first stage feeds the second and nothing else.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sld_sync

/* File: core/sld_bank.sv */
module sld_bank
  import sld_pkg::*;
#(
  parameter int STAGES = SLD_STAGES
) (
  input  wire logic  mclk,
  input  wire logic  rstn,
  sld_shift_if.bank  bus
);

  if (STAGES < 2) begin : g_bad_stages
    $error("sld_bank needs at least two stages");
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.stages <= {STAGES{SLD_DATA_RST}};
    end else if (bus.shift_en) begin
      bus.stages <= {bus.stages[STAGES-2:0], bus.din};
    end
  end

  // Transparent latch modelled as a register that copies while enabled.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bus.latched <= {STAGES{SLD_DATA_RST}};
    end else if (bus.latch_en) begin
      bus.latched <= bus.stages;
    end
  end

endmodule // sld_bank

/* File: core/sld_top.sv */
// Function
// - Sixteen-stage shift register loads serial input into stage one on each clock rise.
// - Each clock rise moves every stage one step toward the serial output.
// - Serial output shows the last stage for cascading.
// - Latch enable high makes all sixteen latches copy their shift stages.
// - Latches track while enable stays high and hold when it is low.
// - Sixteen sink outputs, each driven by one latch bit.
// - Output enable high blanks every sink at once.
// - Output enable never changes the stored latch contents.
// - With output enable low each sink follows its own latch.
// - Undriven output enable reads high, undriven latch enable reads low.
// - Serial output moves only on shift clock rises, never on enables.
module sld_top
  import sld_pkg::*;
#(
  parameter int STAGES = SLD_STAGES
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              sdi_pin,
  input  wire logic              sclk_pin,
  input  wire logic              le_pin,
  input  wire logic              le_driven,
  input  wire logic              oe_n_pin,
  input  wire logic              oe_n_driven,
  output logic                   sdo,
  output logic [STAGES-1:0]      sink_on,
  output logic                   pattern_valid
);

  localparam int CNT_W = $clog2(STAGES + 1);
  localparam logic [SLD_PIN_NUM-1:0] PIN_RST = {SLD_SDI_RST, SLD_SCLK_RST, SLD_LE_PULL, SLD_OE_N_PULL};

  if (STAGES < 2) begin : g_bad_stages
    $error("sld_top needs at least two stages");
  end

  logic [SLD_PIN_NUM-1:0] pin_raw;
  logic [SLD_PIN_NUM-1:0] pin_s;
  logic                   sclk_prev_q;
  logic                   shift_rise;
  logic                   oe_s;
  logic [CNT_W-1:0]       shift_cnt_q;
  sld_load_t              load_q;
  logic [STAGES-1:0]      sink_q;

  sld_shift_if #(.STAGES(STAGES)) bus ();

  // An unconnected enable pin is modelled by its driven flag; the pull level
  // is chosen before synchronising so the pull and the pin share one path.
  always_comb begin
    pin_raw                = '0;
    pin_raw[SLD_PIN_SDI]   = sdi_pin;
    pin_raw[SLD_PIN_SCLK]  = sclk_pin;
    pin_raw[SLD_PIN_LE]    = le_driven ? le_pin : SLD_LE_PULL;
    pin_raw[SLD_PIN_OE_N]  = oe_n_driven ? oe_n_pin : SLD_OE_N_PULL;
  end

  sld_sync #(
    .WIDTH   (SLD_PIN_NUM),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .mclk     (mclk),
    .rstn     (rstn),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  // The previous level resets high so a clock idling high at reset release
  // is not mistaken for a rising edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= SLD_SCLK_RST;
    end else begin
      sclk_prev_q <= pin_s[SLD_PIN_SCLK];
    end
  end

  // Data and clock cross through matched stages, so the data seen here is
  // the level present at the pin when the clock rose.
  assign shift_rise   = pin_s[SLD_PIN_SCLK] & ~sclk_prev_q;
  assign bus.shift_en = shift_rise;
  assign bus.din      = pin_s[SLD_PIN_SDI];
  assign bus.latch_en = pin_s[SLD_PIN_LE];
  assign oe_s         = pin_s[SLD_PIN_OE_N];

  sld_bank #(
    .STAGES (STAGES)
  ) u_bank (
    .mclk (mclk),
    .rstn (rstn),
    .bus  (bus)
  );

  // Only the shift register feeds the serial output, so the enables can
  // never disturb it.
  assign sdo = bus.stages[STAGES-1];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sink_q <= {STAGES{SLD_SINK_RST}};
    end else if (oe_s) begin
      sink_q <= {STAGES{SLD_SINK_RST}};
    end else begin
      sink_q <= bus.latched;
    end
  end

  assign sink_on = sink_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      shift_cnt_q <= '0;
    end else if (shift_rise && load_q == SLD_ST_UNKNOWN) begin
      shift_cnt_q <= shift_cnt_q + CNT_W'(1);
    end
  end

  // Loaded data are trusted only once every stage has been written and a
  // latch strobe has copied them; there is no reset pin on the real part.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      load_q <= SLD_ST_UNKNOWN;
    end else begin
      case (load_q)
        SLD_ST_UNKNOWN: begin
          if (shift_rise && shift_cnt_q == CNT_W'(STAGES - 1)) begin
            load_q <= SLD_ST_FILLED;
          end
        end
        SLD_ST_FILLED: begin
          if (bus.latch_en) begin
            load_q <= SLD_ST_VALID;
          end
        end
        SLD_ST_VALID: begin
          load_q <= SLD_ST_VALID;
        end
        default: begin
          load_q <= SLD_ST_UNKNOWN;
        end
      endcase
    end
  end

  assign pattern_valid = (load_q == SLD_ST_VALID);

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!rstn);

  sequence s_pin_rise;
    $rose(sclk_pin) ##1 sclk_pin;
  endsequence

  sequence s_tail_shift;
    shift_rise ##1 1'b1;
  endsequence

  sequence s_last_fill;
    shift_rise && load_q == SLD_ST_UNKNOWN && shift_cnt_q == CNT_W'(STAGES - 1);
  endsequence

  sequence s_oe_float;
    !oe_n_driven [*3];
  endsequence

  sequence s_le_float;
    !le_driven [*3];
  endsequence

  sequence s_le_high;
    (le_driven && le_pin) [*2];
  endsequence

  sequence s_oe_high;
    (oe_n_driven && oe_n_pin) [*3];
  endsequence

  sequence s_oe_low;
    (oe_n_driven && !oe_n_pin) [*3];
  endsequence

  sequence s_open_shift;
    bus.latch_en && shift_rise ##1 bus.latch_en;
  endsequence

  property p_first_stage;
    shift_rise |=> bus.stages[0] == $past(bus.din);
  endproperty

  property p_stage_move;
    shift_rise |=> bus.stages[STAGES-1:1] == $past(bus.stages[STAGES-2:0]);
  endproperty

  chk_first_stage: assert property (p_first_stage)
    else $error("First stage did not capture the serial input.");

  chk_pin_to_shift: assert property (s_pin_rise |-> ##1 shift_rise)
    else $error("Shift clock rise at the pin did not shift in time.");

  chk_stage_move: assert property (p_stage_move)
    else $error("Stages did not move one step on a shift.");

  chk_stage_hold: assert property (!shift_rise |=> $stable(bus.stages))
    else $error("Stages changed without a shift clock rise.");

  chk_sdo_tail: assert property (s_tail_shift |-> sdo == $past(bus.stages[STAGES-2], 2))
    else $error("Serial output does not show the last stage.");

  chk_latch_copy: assert property (bus.latch_en |=> bus.latched == $past(bus.stages))
    else $error("Latches did not copy the stages while enabled.");

  chk_latch_track: assert property (bus.latch_en [*2] |=> bus.latched == $past(bus.stages))
    else $error("Latches stopped tracking while enable stayed high.");

  chk_latch_hold: assert property (!bus.latch_en |=> $stable(bus.latched))
    else $error("Latches changed while enable was low.");

  chk_sink_source: assert property (!oe_s && !bus.latch_en |=> sink_on == bus.latched)
    else $error("Sink outputs do not follow their latch bits.");

  chk_blank_all: assert property (oe_s |=> sink_on == '0)
    else $error("A sink stayed on while outputs were blanked.");

  chk_blank_keep: assert property (oe_s && !bus.latch_en |=> $stable(bus.latched))
    else $error("Blanking disturbed the latched pattern.");

  chk_unblank: assert property ($fell(oe_s) && !bus.latch_en |=> sink_on == bus.latched)
    else $error("Unblanking did not restore the latched pattern.");

  chk_sink_map: assert property (!oe_s |=> sink_on == $past(bus.latched))
    else $error("Enabled sinks do not match the latches.");

  chk_oe_pull: assert property (s_oe_float |-> oe_s)
    else $error("Undriven output enable did not blank the sinks.");

  chk_le_pull: assert property (s_le_float |-> !bus.latch_en)
    else $error("Undriven latch enable did not hold the latches.");

  chk_sdo_quiet: assert property (!shift_rise |=> $stable(sdo))
    else $error("Serial output moved without a shift clock rise.");

  chk_fill_done: assert property (s_last_fill |=> load_q == SLD_ST_FILLED)
    else $error("Sixteenth shift did not mark the register filled.");

  chk_valid_cause: assert property ($rose(pattern_valid) |-> $past(bus.latch_en) && $past(load_q) == SLD_ST_FILLED)
    else $error("Pattern marked valid without a full shift and latch.");

  chk_valid_sticky: assert property (pattern_valid |=> pattern_valid)
    else $error("Pattern valid dropped without a reset.");

  chk_count_bound: assert property (load_q == SLD_ST_UNKNOWN |-> shift_cnt_q < CNT_W'(STAGES))
    else $error("Fill counter ran past the stage count.");

  // Several of these checks start from the pins, so a wrong synchroniser depth or a swapped
  // pin position shows up even where the internal checks agree with each other.
  chk_shift_single: assert property (shift_rise |=> !shift_rise)
    else $error("One shift clock rise gave more than one shift.");

  chk_shift_cause: assert property (shift_rise |-> $past(sclk_pin, 2) && !$past(sclk_pin, 3))
    else $error("Shift strobe without a matching rise at the clock pin.");

  chk_din_source: assert property (shift_rise |-> bus.din == $past(sdi_pin, 2))
    else $error("Shifted bit is not the level seen at the data pin.");

  chk_sdo_next: assert property (shift_rise |=> sdo == $past(bus.stages[STAGES-2]))
    else $error("Serial output did not take the stage before it.");

  chk_latch_pin: assert property (s_le_high |-> ##1 bus.latch_en)
    else $error("Latch enable at the pin did not open the latches.");

  chk_latch_follow: assert property (s_open_shift |=> bus.latched[0] == $past(bus.din, 2))
    else $error("Open latches did not follow a new shift.");

  chk_blank_pin: assert property (s_oe_high |=> sink_on == '0)
    else $error("Output enable high at the pin left a sink on.");

  chk_blank_latch: assert property (oe_s && bus.latch_en |=> bus.latched == $past(bus.stages))
    else $error("Blanking stopped the latches from loading.");

  chk_enable_pin: assert property (s_oe_low |=> sink_on == $past(bus.latched))
    else $error("Output enable low at the pin did not show the latches.");

  chk_oe_float_blank: assert property (s_oe_float |=> sink_on == '0)
    else $error("Undriven output enable left a sink on.");

  chk_le_float_hold: assert property (s_le_float |=> $stable(bus.latched))
    else $error("Undriven latch enable let the latches change.");

  chk_sdo_cause: assert property ($changed(sdo) |-> $past(shift_rise))
    else $error("Serial output changed without a shift.");

  chk_fill_count: assert property ($rose(pattern_valid) |-> shift_cnt_q == CNT_W'(STAGES))
    else $error("Pattern marked valid before every stage was written.");

  chk_count_freeze: assert property (load_q != SLD_ST_UNKNOWN |=> $stable(shift_cnt_q))
    else $error("Fill counter moved after the register was filled.");

endmodule // sld_top

/* File: verif/sld_host_model.sv */
module sld_host_model (
  input  wire logic mclk,
  output logic      sdi_pin,
  output logic      sclk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sdi_pin  = 1'b0;
    sclk_pin = 1'b0;
  end

  // Call at a falling edge of mclk; one bit takes 8 mclk, so the link clock runs at 200 ns.
  // The link clock rests low between bits, and sdi is inverted once its hold time has passed.
  // A stale copy of the bit would hide a late sampling point in the design.
  task automatic send_bit(input logic b);
    sdi_pin = b;
    repeat (2) @(negedge mclk);
    sclk_pin = 1'b1;
    repeat (2) @(negedge mclk);
    sdi_pin = ~b;
    repeat (2) @(negedge mclk);
    sclk_pin = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
endmodule // sld_host_model

/* File: verif/sld_top_tb_top.sv */
module sld_top_tb_top import sld_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              mclk        = 1'b0;
  logic              rstn        = 1'b0;
  logic              le_pin      = 1'b0;
  logic              le_driven   = 1'b1;
  logic              oe_n_pin    = 1'b0;
  logic              oe_n_driven = 1'b1;
  logic              sdi_pin;
  logic              sclk_pin;
  logic              sdo;
  logic              pattern_valid;
  logic [15:0]       sink_on;
  logic [15:0]       exp_sr      = 16'h0000;
  logic [15:0]       exp_lat     = 16'h0000;
  logic [31:0]       rng         = 32'h00008c65;
  int                error_cnt   = 0;
  int                compares    = 0;

  always #12.5 mclk = ~mclk;

  sld_host_model u_host (.mclk(mclk), .sdi_pin(sdi_pin), .sclk_pin(sclk_pin));

  sld_top #(.STAGES(SLD_STAGES)) u_dut (
    .mclk(mclk), .rstn(rstn), .sdi_pin(sdi_pin), .sclk_pin(sclk_pin), .le_pin(le_pin),
    .le_driven(le_driven), .oe_n_pin(oe_n_pin), .oe_n_driven(oe_n_driven), .sdo(sdo),
    .sink_on(sink_on), .pattern_valid(pattern_valid)
  );

  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction

  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b);
    return {sr[14:0], b};
  endfunction

  function automatic logic [15:0] sink_exp(input logic blank, input logic [15:0] lat);
    return blank ? 16'h0000 : lat;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The expected latches only follow while the latch enable is really seen high.
  task automatic shift_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      u_host.send_bit(w[i]);
      exp_sr = shift_in(exp_sr, w[i]);
      if (le_pin && le_driven) exp_lat = exp_sr;
      check({15'h0, sdo}, {15'h0, exp_sr[15]});
    end
  endtask

  task automatic latch_pulse();
    le_pin = 1'b1;
    cyc(3);
    le_pin = 1'b0;
    cyc(4);
    if (le_driven) exp_lat = exp_sr;
    check({15'h0, sdo}, {15'h0, exp_sr[15]});
  endtask

  task automatic set_oe(input logic v);
    oe_n_pin = v;
    cyc(4);
    check({15'h0, sdo}, {15'h0, exp_sr[15]});
    check(sink_on, sink_exp(v, exp_lat));
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    $display("watchdog expired");
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    logic [15:0] w;
    cyc(12);
    rstn = 1'b1;
    cyc(2);
    check({sink_on[13:0], sdo, pattern_valid}, 16'h0000);
    shift_word(16'h8001);
    check({15'h0, pattern_valid}, 16'h0000);
    check(sink_on, 16'h0000);
    latch_pulse();
    check({15'h0, pattern_valid}, 16'h0001);
    check(sink_on, 16'h8001);
    $display("test first_load done");
    for (int k = 0; k < 4; k++) begin
      w = rnd();
      shift_word(w);
      check(sink_on, exp_lat);
      latch_pulse();
      check(sink_on, w);
      set_oe(1'b1);
      set_oe(1'b0);
    end
    $display("test random_blank done");
    // Latches bypassed: outputs stay blanked while the new word streams through.
    set_oe(1'b1);
    le_pin = 1'b1;
    shift_word(rnd());
    check(sink_on, 16'h0000);
    le_pin = 1'b0;
    cyc(4);
    set_oe(1'b0);
    $display("test transparent done");
    le_driven = 1'b0;
    le_pin = 1'b1;
    shift_word(rnd());
    latch_pulse();
    set_oe(1'b0);
    le_driven = 1'b1;
    oe_n_driven = 1'b0;
    cyc(5);
    check(sink_on, 16'h0000);
    oe_n_driven = 1'b1;
    set_oe(1'b0);
    $display("test undriven done");
    rstn = 1'b0;
    cyc(2);
    check({sink_on[13:0], sdo, pattern_valid}, 16'h0000);
    rstn = 1'b1;
    exp_sr = 16'h0000;
    exp_lat = 16'h0000;
    cyc(2);
    check({sink_on[13:0], sdo, pattern_valid}, 16'h0000);
    w = rnd();
    shift_word(w);
    check({15'h0, pattern_valid}, 16'h0000);
    latch_pulse();
    check({15'h0, pattern_valid}, 16'h0001);
    check(sink_on, w);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule // sld_top_tb_top
